// ---- hw/ebm_pkg.sv ----
// Purpose: constants and types for the external bus master with arbitration
// Assumes: single bus clock, longword reads only, supervisor accesses
// Notes:   see the master module for pin behaviour
//
// Summary of operation
// - bus_request_n low asks arbiter for bus
// - request negates at access start, re-asserts later
// - grant low permits mastership next rising edge
// - grant removed, lock clear: release after transfer
// - lock set keeps mastership until lock cleared
// - drive bus_driven_n when granted and pending/locked
// - granted, idle, unlocked: implicit mastership only
// - grant lost mid-access: finish, then float
// - idle loss, unlocked: negate and float next edge
// - idle loss, locked: keep bus_driven_n asserted
// - first clock: address, kind, size, transfer start
// - second clock: start negated, attribute high
// - sample internal async ack, else wait
// - burst beat repeats with address stepped by port width
// - bus released after final acknowledge edge
// - async ack tied low gives zero wait
// - grant and ack tied low: sole master
// - transfer error aborts whole longword
// - port lanes D[31:0], D[31:16], D[31:24]
// - transfer ack input for own transfers
// - transfer error wins over both acknowledges
// - error shortly after async ack still seen
package ebm_pkg;

    // -------------------------------------------
    // widths and encodings
    // -------------------------------------------
    localparam int         ADDR_W      = 28;
    localparam int         DATA_W      = 32;
    localparam int         BUF_DEPTH   = 2;
    localparam logic [1:0] SIZE_LONG   = 2'h0;
    localparam logic [1:0] PORT_32     = 2'h0;
    localparam logic [1:0] PORT_16     = 2'h1;
    localparam logic [1:0] PORT_8      = 2'h2;
    localparam logic [3:0] ALT_WAIT_RST = 4'h0;
    localparam logic [1:0] BEATS_RST   = 2'h0;

    typedef enum logic [1:0] {
        S_IDLE,
        S_ADDR,
        S_DATA
    } bus_state_t;

endpackage

// ---- hw/ebm_master.sv ----
// Purpose: external bus master with three-wire arbitration and read cycles
// Assumes: inputs synchronous to clock except async_transfer_ack_n
// Notes:   completed longwords pass a two-entry buffer to the core
`timescale 1ns/1ps
module ebm_master
    import ebm_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // core request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [1:0]        req_kind,
    input  wire logic              req_code,
    input  wire logic [1:0]        req_port,
    input  wire logic              bus_lock,
    // read result
    output logic                   rsp_valid,
    input  wire logic              rsp_ready,
    output logic [DATA_W-1:0]      rsp_data,
    output logic                   rsp_error,
    // arbitration pins
    output logic                   bus_request_n,
    input  wire logic              bus_grant_n,
    output logic                   bus_driven_n,
    // address and control pins
    output logic [ADDR_W-1:0]      addr_out,
    output logic [1:0]             transfer_kind,
    output logic                   access_attribute,
    output logic [1:0]             transfer_size,
    output logic                   read_write,
    output logic                   transfer_start_n,
    output logic                   bus_oe_n,
    // termination pins
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              transfer_ack_in_n,
    output logic                   transfer_ack_out_n,
    output logic                   transfer_ack_oe_n,
    input  wire logic              async_transfer_ack_n,
    input  wire logic              transfer_error_n,
    // alternate master chip-select hit
    input  wire logic              alt_hit,
    input  wire logic [3:0]        alt_wait
);

    // -------------------------------------------
    // state
    // -------------------------------------------
    bus_state_t         state;
    logic               ata_s1;
    logic               ata_s2;
    logic [1:0]         beat;
    logic [1:0]         port;
    logic [DATA_W-1:0]  acc;
    logic [DATA_W-1:0]  buf_data [BUF_DEPTH];
    logic               buf_err  [BUF_DEPTH];
    logic               wr_ptr;
    logic               rd_ptr;
    logic [1:0]         count;
    logic [3:0]         alt_count;
    logic               alt_done;
    logic               space;
    logic               pending;
    logic               start;
    logic               ack;
    logic               err;
    logic               last;
    logic               push;
    logic               pop;
    logic [DATA_W-1:0]  next_acc;
    logic [ADDR_W-1:0]  step;

    // -------------------------------------------
    // synchronizer
    // -------------------------------------------
    // second stage only is used; first stage may be metastable
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ata_s1 <= 1'b1;
            ata_s2 <= 1'b1;
        end else begin
            ata_s1 <= async_transfer_ack_n;
            ata_s2 <= ata_s1;
        end
    end

    // -------------------------------------------
    // decode
    // -------------------------------------------
    assign space   = (count < 2'(BUF_DEPTH));
    assign pending = req_valid && space;
    // grant, or held explicit ownership under lock
    assign start   = (state == S_IDLE) && pending &&
                     (!bus_grant_n || (bus_lock && !bus_driven_n));
    assign req_ready = start;
    // error checked first so it always wins
    assign err  = (state == S_DATA) && !transfer_error_n;
    // a tied-low ack finishes in the second clock
    assign ack  = (state == S_DATA) && transfer_error_n &&
                  (!transfer_ack_in_n || !ata_s2);
    assign last = (port == PORT_32) ||
                  (port == PORT_16 && beat == 2'h1) ||
                  (port == PORT_8 && beat == 2'h3);
    assign push = err || (ack && last);
    assign pop  = rsp_valid && rsp_ready;

    always_comb begin
        next_acc = acc;
        step     = 28'h0000004;
        case (port)
            PORT_16: begin
                next_acc = {acc[15:0], data_in[31:16]};
                step     = 28'h0000002;
            end
            PORT_8: begin
                next_acc = {acc[23:0], data_in[31:24]};
                step     = 28'h0000001;
            end
            default: begin
                next_acc = data_in;
            end
        endcase
    end

    // -------------------------------------------
    // cycle sequencer
    // -------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= S_IDLE;
            beat  <= BEATS_RST;
            port  <= PORT_32;
            acc   <= 32'h00000000;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start) begin
                        state <= S_ADDR;
                        beat  <= BEATS_RST;
                        port  <= req_port;
                    end
                end
                S_ADDR: begin
                    state <= S_DATA;
                end
                S_DATA: begin
                    if (err) begin
                        state <= S_IDLE;
                    end else if (ack) begin
                        acc <= next_acc;
                        if (last) begin
                            state <= S_IDLE;
                        end else begin
                            state <= S_ADDR;
                            beat  <= beat + 2'h1;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------
    // address and control outputs
    // -------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            addr_out         <= 28'h0000000;
            transfer_kind    <= 2'h0;
            access_attribute <= 1'b0;
            transfer_size    <= SIZE_LONG;
            read_write       <= 1'b1;
            transfer_start_n <= 1'b1;
        end else begin
            transfer_start_n <= 1'b1;
            if (start) begin
                addr_out         <= req_addr;
                transfer_kind    <= req_kind;
                access_attribute <= req_code;
                transfer_size    <= SIZE_LONG;
                read_write       <= 1'b1;
                transfer_start_n <= 1'b0;
            end else if (state == S_ADDR) begin
                access_attribute <= 1'b1;
            end else if (ack && !last) begin
                addr_out         <= addr_out + step;
                access_attribute <= req_code;
                transfer_start_n <= 1'b0;
            end
        end
    end

    // -------------------------------------------
    // arbitration
    // -------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            bus_request_n <= 1'b1;
        end else if (start) begin
            bus_request_n <= 1'b1;
        end else if (pending && bus_grant_n && state == S_IDLE) begin
            bus_request_n <= 1'b0;
        end
    end

    // the arbiter must not hand over until this negates
    always_ff @(posedge clock) begin
        if (!nrst) begin
            bus_driven_n <= 1'b1;
        end else if (start || state == S_ADDR || (state == S_DATA && !push)) begin
            bus_driven_n <= 1'b0;
        end else if (push) begin
            // access done: keep only if grant stays or lock holds
            bus_driven_n <= !(!bus_grant_n || bus_lock);
        end else if (!bus_grant_n && bus_lock) begin
            bus_driven_n <= 1'b0;
        end else if (!bus_driven_n && bus_lock) begin
            bus_driven_n <= 1'b0;
        end else begin
            bus_driven_n <= 1'b1;
        end
    end

    // floats whenever no access runs and ownership is only implicit
    assign bus_oe_n = (state == S_IDLE) && bus_driven_n;

    // -------------------------------------------
    // alternate master acknowledge
    // -------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            alt_count          <= ALT_WAIT_RST;
            alt_done           <= 1'b0;
            transfer_ack_out_n <= 1'b1;
            transfer_ack_oe_n  <= 1'b1;
        end else begin
            transfer_ack_out_n <= 1'b1;
            transfer_ack_oe_n  <= 1'b1;
            if (!alt_hit || !bus_oe_n) begin
                alt_count <= ALT_WAIT_RST;
                alt_done  <= 1'b0;
            end else if (!alt_done) begin
                if (alt_count == alt_wait) begin
                    transfer_ack_out_n <= 1'b0;
                    transfer_ack_oe_n  <= 1'b0;
                    alt_done           <= 1'b1;
                end else begin
                    alt_count <= alt_count + 4'h1;
                end
            end
        end
    end

    // -------------------------------------------
    // result buffer
    // -------------------------------------------
    // a stalled core blocks new accesses instead of losing words
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= !wr_ptr;
            end
            if (pop) begin
                rd_ptr <= !rd_ptr;
            end
            count <= count + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            buf_data[wr_ptr] <= err ? 32'h00000000 : next_acc;
            buf_err[wr_ptr]  <= err;
        end
    end

    assign rsp_valid = (count != 2'h0);
    assign rsp_data  = buf_data[rd_ptr];
    assign rsp_error = rsp_valid && buf_err[rd_ptr];

    // -------------------------------------------
    // checks
    // -------------------------------------------
    sequence s_first;
        !transfer_start_n && state == S_ADDR;
    endsequence

    sequence s_second;
        transfer_start_n && access_attribute;
    endsequence

    property p_request;
        @(posedge clock) disable iff (!nrst)
        (state == S_IDLE && pending && bus_grant_n && !start) |=> !bus_request_n;
    endproperty
    a_request: assert property (p_request) else $error("request not raised");

    property p_request_drop;
        @(posedge clock) disable iff (!nrst)
        start |=> bus_request_n [*2];
    endproperty
    a_request_drop: assert property (p_request_drop) else $error("request held");

    property p_cycle;
        @(posedge clock) disable iff (!nrst)
        start |=> s_first ##1 s_second;
    endproperty
    a_cycle: assert property (p_cycle) else $error("bad cycle start");

    property p_driven;
        @(posedge clock) disable iff (!nrst)
        start |=> !bus_driven_n && !bus_oe_n;
    endproperty
    a_driven: assert property (p_driven) else $error("bus not driven");

    property p_implicit;
        @(posedge clock) disable iff (!nrst)
        (state == S_IDLE && !bus_grant_n && !req_valid && !bus_lock && bus_driven_n)
        |=> bus_driven_n;
    endproperty
    a_implicit: assert property (p_implicit) else $error("driven while implicit");

    property p_release;
        @(posedge clock) disable iff (!nrst)
        (state == S_IDLE && bus_grant_n && !bus_lock) |=> bus_driven_n && bus_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("bus not released");

    property p_lock;
        @(posedge clock) disable iff (!nrst)
        (!bus_driven_n && bus_lock) |=> !bus_driven_n;
    endproperty
    a_lock: assert property (p_lock) else $error("lock lost ownership");

    property p_error;
        @(posedge clock) disable iff (!nrst)
        err |=> state == S_IDLE && rsp_valid && $past(ack) == 1'b0;
    endproperty
    a_error: assert property (p_error) else $error("error not aborting");

    property p_burst;
        @(posedge clock) disable iff (!nrst)
        (ack && !last) |=> !transfer_start_n && addr_out == $past(addr_out) + $past(step);
    endproperty
    a_burst: assert property (p_burst) else $error("burst address wrong");

    property p_ack_in;
        @(posedge clock) disable iff (!nrst)
        !bus_oe_n |=> transfer_ack_oe_n;
    endproperty
    a_ack_in: assert property (p_ack_in) else $error("ack driven in own cycle");

endmodule

// ---- bench/ebm_far.sv ----
// Purpose: far-side arbiter and memory model for the bus master bench
// Assumes: one slave; each word is a pattern made from the address low byte
// Notes:   mode 0 sync ack, 1 async ack, 2 error with ack, 3 async tied low
`timescale 1ns/1ps
module ebm_far
    import ebm_pkg::*;
(
    // clock, reset and scenario controls
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              grant_on,
    input  wire logic              auto_grant,
    input  wire logic [1:0]        mode,
    input  wire logic [1:0]        waits,
    // bus pins
    input  wire logic              bus_request_n,
    output logic                   bus_grant_n,
    input  wire logic [ADDR_W-1:0] addr_out,
    input  wire logic              transfer_start_n,
    output logic [DATA_W-1:0]      data_in,
    output logic                   transfer_ack_in_n,
    output logic                   async_transfer_ack_n,
    output logic                   transfer_error_n
);
    logic       busy;
    logic       fire;
    logic [1:0] cnt;
    logic [1:0] tail;
    logic [7:0] b;
    // no second master here, so withdrawing grant is the only handover
    always_ff @(posedge clock) begin
        bus_grant_n <= !nrst || !(grant_on || (auto_grant && !bus_request_n));
    end
    always_ff @(posedge clock) begin
        if (!nrst || !transfer_start_n) begin
            busy <= nrst;
            cnt  <= waits;
            b    <= addr_out[7:0];
        end else if (busy) begin
            busy <= (cnt != 2'h0);
            cnt  <= cnt - 2'h1;
        end
        tail <= !nrst ? 2'h0 : busy ? 2'h3 : (tail == 2'h0 ? 2'h0 : tail - 2'h1);
    end
    // data held past the ack so the synchronised ack still latches it
    assign data_in = (busy || tail != 2'h0) ? {b, ~b, b ^ 8'h5A, 8'hC3}
                                            : ~{b, ~b, b ^ 8'h5A, 8'hC3};
    assign fire = busy && (cnt == 2'h0);
    assign transfer_ack_in_n = !(fire && (mode == 2'h0 || mode == 2'h2));
    // async ack held one full clock, or tied low for zero wait
    assign async_transfer_ack_n = (mode == 2'h3) ? 1'b0 : !(fire && mode == 2'h1);
    assign transfer_error_n = !(fire && mode == 2'h2);
endmodule

// ---- bench/test_external_bus_master_arbitration.sv ----
// Purpose: self-checking bench for the external bus master
// Assumes: far-side model answers from the address low byte
// Notes:   issued addresses are longword aligned, burst beats step within the low byte with no carry out
`timescale 1ns/1ps
module test_external_bus_master_arbitration;
    import ebm_pkg::*;
    logic              clock = 0, nrst = 0, req_valid = 0, req_code = 0, bus_lock = 0;
    logic              rsp_ready = 0, alt_hit = 0, grant_on = 0, auto_grant = 0;
    logic [ADDR_W-1:0] req_addr = '0, addr_out;
    logic [1:0]        req_kind = 0, req_port = 0, mode = 0, waits = 0, transfer_kind;
    logic [1:0]        transfer_size;
    logic [3:0]        alt_wait = 0;
    logic [DATA_W-1:0] rsp_data, data_in;
    logic req_ready, rsp_valid, rsp_error, bus_request_n, bus_grant_n, bus_driven_n;
    logic access_attribute, read_write, transfer_start_n, bus_oe_n, transfer_ack_in_n;
    logic transfer_ack_out_n, transfer_ack_oe_n, async_transfer_ack_n, transfer_error_n;
    logic prev_ts = 0, seen_req = 0;
    logic [7:0] ts_b[$];
    int err_total = 0, checks_done = 0, lat, n;

    always #10 clock = ~clock;

    ebm_master u_ebm_master (
        .clock                (clock),
        .nrst                 (nrst),
        .req_valid            (req_valid),
        .req_ready            (req_ready),
        .req_addr             (req_addr),
        .req_kind             (req_kind),
        .req_code             (req_code),
        .req_port             (req_port),
        .bus_lock             (bus_lock),
        .rsp_valid            (rsp_valid),
        .rsp_ready            (rsp_ready),
        .rsp_data             (rsp_data),
        .rsp_error            (rsp_error),
        .bus_request_n        (bus_request_n),
        .bus_grant_n          (bus_grant_n),
        .bus_driven_n         (bus_driven_n),
        .addr_out             (addr_out),
        .transfer_kind        (transfer_kind),
        .access_attribute     (access_attribute),
        .transfer_size        (transfer_size),
        .read_write           (read_write),
        .transfer_start_n     (transfer_start_n),
        .bus_oe_n             (bus_oe_n),
        .data_in              (data_in),
        .transfer_ack_in_n    (transfer_ack_in_n),
        .transfer_ack_out_n   (transfer_ack_out_n),
        .transfer_ack_oe_n    (transfer_ack_oe_n),
        .async_transfer_ack_n (async_transfer_ack_n),
        .transfer_error_n     (transfer_error_n),
        .alt_hit              (alt_hit),
        .alt_wait             (alt_wait)
    );
    ebm_far u_ebm_far (
        .clock                (clock),
        .nrst                 (nrst),
        .grant_on             (grant_on),
        .auto_grant           (auto_grant),
        .mode                 (mode),
        .waits                (waits),
        .bus_request_n        (bus_request_n),
        .bus_grant_n          (bus_grant_n),
        .addr_out             (addr_out),
        .transfer_start_n     (transfer_start_n),
        .data_in              (data_in),
        .transfer_ack_in_n    (transfer_ack_in_n),
        .async_transfer_ack_n (async_transfer_ack_n),
        .transfer_error_n     (transfer_error_n)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (err_total == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    function automatic logic [31:0] exp_word(input logic [7:0] b, input logic [1:0] p);
        if (p == PORT_16) return {b, ~b, b + 8'h02, ~(b + 8'h02)};
        if (p == PORT_8) return {b, b + 8'h01, b + 8'h02, b + 8'h03};
        return {b, ~b, b ^ 8'h5A, 8'hC3};
    endfunction

    // -------------------------------------------
    // pin monitor
    // -------------------------------------------
    always @(negedge clock) begin
        if (bus_request_n === 1'b0) seen_req = 1'b1;
        if (prev_ts) check(32'(access_attribute), 32'h1);
        if (prev_ts) check(32'(transfer_start_n), 32'h1);
        if (transfer_start_n === 1'b0) begin
            ts_b.push_back(addr_out[7:0]);
            check(32'(transfer_size), 32'(SIZE_LONG));
            check({read_write, access_attribute, bus_oe_n}, {1'b1, req_code, 1'b0});
            check(32'(transfer_kind), 32'(req_kind));
        end
        prev_ts = (transfer_start_n === 1'b0);
    end

    // -------------------------------------------
    // shared bus steps
    // -------------------------------------------
    task automatic issue(input logic [7:0] b, input logic [1:0] p);
        @(posedge clock);
        req_valid <= 1'b1;
        req_addr <= {20'h01234, b};
        req_port <= p;
        req_kind <= p;
        ts_b.delete();
        n = 0;
        do @(negedge clock); while (req_ready !== 1'b1 && ++n < 300);
        @(posedge clock);
        req_valid <= 1'b0;
        lat = 0;
        while (rsp_valid !== 1'b1 && lat < 300) begin
            @(negedge clock);
            lat++;
        end
    endtask

    task automatic pop(input logic [31:0] d, input logic e);
        @(negedge clock);
        check({rsp_valid, rsp_error}, {1'b1, e});
        check(rsp_data, d);
        @(posedge clock);
        rsp_ready <= 1'b1;
        @(posedge clock);
        rsp_ready <= 1'b0;
    endtask

    task automatic read(input logic [7:0] b, input logic [1:0] p);
        issue(b, p);
        pop(exp_word(b, p), 1'b0);
    endtask

    // -------------------------------------------
    // scenarios
    // -------------------------------------------
    task automatic t_zero_wait();
        grant_on <= 1'b1;
        read(8'h40, PORT_32);
        check(lat, 3);
        check(32'(ts_b[0]), 32'h40);
        mode <= 2'h3;
        read(8'h44, PORT_32);
        check(lat, 3);
    endtask

    task automatic t_burst_grant_drop();
        mode <= 2'h0;
        waits <= 2'h1;
        fork
            read(8'h80, PORT_16);
            repeat (3) @(posedge clock) grant_on <= 1'b0;
        join
        check(32'(ts_b.size()), 2);
        check(32'(ts_b[1]), 32'h82);
        check({bus_driven_n, bus_oe_n}, 2'b11);
    endtask

    task automatic t_request_async8();
        auto_grant <= 1'b1;
        seen_req = 1'b0;
        mode <= 2'h1;
        read(8'hA0, PORT_8);
        check(32'(seen_req), 1);
        check(32'(bus_request_n), 1);
        check(32'(ts_b.size()), 4);
    endtask

    task automatic t_error();
        mode <= 2'h2;
        req_code <= 1'b1;
        issue(8'hC0, PORT_16);
        pop(32'h0, 1'b1);
        check(32'(ts_b.size()), 1);
    endtask

    task automatic t_lock();
        auto_grant <= 1'b0;
        grant_on <= 1'b1;
        repeat (4) @(negedge clock);
        check(32'(bus_driven_n), 1);
        @(posedge clock);
        bus_lock <= 1'b1;
        repeat (3) @(negedge clock);
        check(32'(bus_driven_n), 0);
        @(posedge clock);
        grant_on <= 1'b0;
        repeat (4) @(negedge clock);
        check(32'(bus_driven_n), 0);
        @(posedge clock);
        bus_lock <= 1'b0;
        repeat (2) @(negedge clock);
        check({bus_driven_n, bus_oe_n}, 2'b11);
        @(posedge clock);
    endtask

    task automatic t_buffer();
        grant_on <= 1'b1;
        mode <= 2'h0;
        issue(8'h10, PORT_32);
        issue(8'h20, PORT_32);
        @(posedge clock);
        req_valid <= 1'b1;
        repeat (4) @(negedge clock);
        check(32'(req_ready), 0); // buffer full refuses
        @(posedge clock);
        req_valid <= 1'b0;
        pop(exp_word(8'h10, PORT_32), 1'b0);
        pop(exp_word(8'h20, PORT_32), 1'b0);
        @(negedge clock);
        check(32'(rsp_valid), 0);
        @(posedge clock);
    endtask

    task automatic t_alt_ack();
        grant_on <= 1'b0;
        repeat (3) @(posedge clock);
        alt_wait <= 4'h2;
        alt_hit <= 1'b1;
        n = 0;
        do @(negedge clock); while (transfer_ack_oe_n !== 1'b0 && ++n < 40);
        check(n, 3);
        check(32'(transfer_ack_out_n), 0);
        @(negedge clock);
        check(32'(transfer_ack_oe_n), 1);
        @(posedge clock);
        alt_hit <= 1'b0;
    endtask

    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        check({bus_request_n, bus_driven_n, transfer_start_n, bus_oe_n}, 4'hF);
        @(posedge clock);
        t_zero_wait();
        t_burst_grant_drop();
        t_request_async8();
        t_error();
        t_lock();
        t_buffer();
        t_alt_ack();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        report_and_stop();
    end
endmodule
